// >>> inc/dsscs_regs.vh
// Register offsets, field layouts, reset values and timing constants of the serial slave supervisor.
`ifndef DSSCS_REGS_VH
`define DSSCS_REGS_VH
`define DSSCS_ADDR_CFG       4'h0
`define DSSCS_ADDR_TMO       4'h1
`define DSSCS_ADDR_ERRLIM    4'h2
`define DSSCS_ADDR_TURN      4'h3
`define DSSCS_ADDR_STATUS    4'h4
`define DSSCS_ADDR_IRQ_STAT  4'h5
`define DSSCS_ADDR_IRQ_CLR   4'h6
`define DSSCS_ADDR_IRQ_EN    4'h7
`define DSSCS_ADDR_ERRCNT    4'h8
`define DSSCS_CFG_RESET      32'h00000001
`define DSSCS_TMO_RESET      8'h00
`define DSSCS_ERRLIM_RESET   5'h01
`define DSSCS_TURN_RESET     7'h05
`define DSSCS_STATION_MIN    6'h01
`define DSSCS_STATION_MAX    6'h20
`define DSSCS_ERRLIM_MIN     5'h01
`define DSSCS_ERRLIM_MAX     5'h14
`define DSSCS_TURN_MIN       7'h05
`define DSSCS_TURN_MAX       7'h41
`define DSSCS_CFG_STATION_LSB 0
`define DSSCS_CFG_MODE_BIT    8
`define DSSCS_CFG_BAUD_LSB    9
`define DSSCS_CFG_STOP_BIT    11
`define DSSCS_CFG_PAR_LSB     12
`define DSSCS_CFG_SEVEN_BIT   14
`define DSSCS_CFG_REACT_LSB   16
`define DSSCS_CLK_HZ         50000000
`define DSSCS_BAUD0          4800
`define DSSCS_BAUD1          9600
`define DSSCS_BAUD2          19200
`define DSSCS_BAUD3          38400
`define DSSCS_TENTH_S_NS     100000000
`define DSSCS_MS_NS          1000000
`define DSSCS_CLK_NS         20
`define DSSCS_REACT_DEC1     2'h0
`define DSSCS_REACT_COAST    2'h1
`define DSSCS_REACT_DEC2     2'h2
`define DSSCS_REACT_RUN      2'h3
`define DSSCS_EV_TIMEOUT     0
`define DSSCS_EV_ERRLIM      1
`define DSSCS_EV_FRAME       2
`define DSSCS_EV_ERROR       3
`define DSSCS_NEV            4
`endif

// >>> hdl/dsscs_ticker.v
// Programmable tick counter used for baud, timeout and turnaround timing.
`timescale 1ns/1ps
module dsscs_ticker #(
	parameter W = 32
) (
	input  wire         clk,
	input  wire         nrst,
	input  wire         ce,
	input  wire         restart,
	input  wire [W-1:0] period,
	output reg          tick
);
	reg [W-1:0] cnt_reg;

	// Tick fires once every period cycles; restart realigns the phase to the caller.
	always @(posedge clk) begin
		if (!nrst) begin
			cnt_reg <= {W{1'b0}};
			tick    <= 1'b0;
		end else if (ce) begin
			if (restart || cnt_reg + 1'b1 >= period) begin
				cnt_reg <= {W{1'b0}};
				tick    <= ~restart;
			end else begin
				cnt_reg <= cnt_reg + 1'b1;
				tick    <= 1'b0;
			end
		end
	end
endmodule

// >>> hdl/dsscs_top.v
// Serial slave link supervisor with framing, timeout, error tolerance and reply turnaround.
`timescale 1ns/1ps
`include "dsscs_regs.vh"
module dsscs_top #(
	parameter TMO_TENTH_CYC = `DSSCS_TENTH_S_NS / `DSSCS_CLK_NS,
	parameter TURN_MS_CYC   = `DSSCS_MS_NS / `DSSCS_CLK_NS
) (
	input  wire        clk,
	input  wire        nrst,
	input  wire        ce,
	input  wire [3:0]  wb_adr_i,
	input  wire [31:0] wb_dat_i,
	input  wire [3:0]  wb_sel_i,
	input  wire        wb_we_i,
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	output reg         wb_err_o,
	input  wire        rx_i,
	output reg         tx_o,
	output reg         tx_en_o,
	input  wire        frame_end_i,
	input  wire [7:0]  frame_addr_i,
	input  wire        frame_bad_i,
	input  wire        reply_req_i,
	output reg         reply_go_o,
	output reg         rx_bit_o,
	output reg         rx_strobe_o,
	output reg         link_timeout_indication,
	output reg         link_error_limit_indication,
	output reg  [1:0]  stop_action_o,
	output reg         irq_o
);
	// Rate divisors in clock cycles for each baud code.
	localparam [31:0] DIV0 = `DSSCS_CLK_HZ / `DSSCS_BAUD0;
	localparam [31:0] DIV1 = `DSSCS_CLK_HZ / `DSSCS_BAUD1;
	localparam [31:0] DIV2 = `DSSCS_CLK_HZ / `DSSCS_BAUD2;
	localparam [31:0] DIV3 = `DSSCS_CLK_HZ / `DSSCS_BAUD3;

	reg [31:0] cfg_reg;
	reg [7:0]  tmo_reg;
	reg [4:0]  errlim_reg;
	reg [6:0]  turn_reg;
	reg [`DSSCS_NEV-1:0] ist_reg;
	reg [`DSSCS_NEV-1:0] ien_reg;
	reg [`DSSCS_NEV-1:0] ev_next;
	reg [4:0]  errcnt_reg;
	reg [7:0]  tmo_cnt_reg;
	reg [6:0]  turn_cnt_reg;
	reg        turn_busy_reg;
	reg [31:0] div_next;
	reg [31:0] rd_next;

	wire [5:0] station   = cfg_reg[`DSSCS_CFG_STATION_LSB +: 6];
	wire       ascii     = cfg_reg[`DSSCS_CFG_MODE_BIT];
	wire [1:0] baud      = cfg_reg[`DSSCS_CFG_BAUD_LSB +: 2];
	wire       two_stop  = cfg_reg[`DSSCS_CFG_STOP_BIT];
	wire [1:0] parity    = cfg_reg[`DSSCS_CFG_PAR_LSB +: 2];
	wire       seven     = cfg_reg[`DSSCS_CFG_SEVEN_BIT];
	wire [1:0] react     = cfg_reg[`DSSCS_CFG_REACT_LSB +: 2];
	wire       wb_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
	wire       wr        = wb_req & wb_we_i & (wb_sel_i == 4'hF);
	wire       tenth_tick;
	wire       ms_tick;
	wire       bit_tick;

	// Station match: the address byte must equal the programmed station, broadcast is not answered.
	wire for_me  = frame_end_i & (frame_addr_i == {2'b00, station});
	wire good_fr = for_me & ~frame_bad_i;
	wire bad_fr  = frame_end_i & frame_bad_i;

	// Baud divisor selection by rate code.
	always @* begin
		case (baud)
		2'h0: div_next = DIV0;
		2'h1: div_next = DIV1;
		2'h2: div_next = DIV2;
		default: div_next = DIV3;
		endcase
	end

	dsscs_ticker #(.W(32)) u_bit (
		.clk(clk), .nrst(nrst), .ce(ce), .restart(1'b0), .period(div_next), .tick(bit_tick)
	);
	dsscs_ticker #(.W(32)) u_tenth (
		.clk(clk), .nrst(nrst), .ce(ce), .restart(good_fr), .period(TMO_TENTH_CYC), .tick(tenth_tick)
	);
	dsscs_ticker #(.W(32)) u_ms (
		.clk(clk), .nrst(nrst), .ce(ce), .restart(frame_end_i & ~turn_busy_reg),
		.period(TURN_MS_CYC), .tick(ms_tick)
	);

	// Bit sampler: rx is sampled once per bit time and presented with a strobe.
	always @(posedge clk) begin
		if (!nrst) begin
			rx_bit_o    <= 1'b1;
			rx_strobe_o <= 1'b0;
		end else if (ce) begin
			rx_strobe_o <= bit_tick;
			if (bit_tick)
				rx_bit_o <= rx_i;
		end
	end

	// Timeout supervision; the timer restarts on every good addressed frame.
	always @(posedge clk) begin
		if (!nrst) begin
			tmo_cnt_reg             <= 8'h00;
			link_timeout_indication <= 1'b0;
			stop_action_o           <= `DSSCS_REACT_RUN;
		end else if (ce) begin
			if (good_fr) begin
				tmo_cnt_reg             <= 8'h00;
				link_timeout_indication <= 1'b0;
				stop_action_o           <= `DSSCS_REACT_RUN;
			end else if (tmo_reg == `DSSCS_TMO_RESET) begin
				tmo_cnt_reg             <= 8'h00;
				link_timeout_indication <= 1'b0;
				stop_action_o           <= `DSSCS_REACT_RUN;
			end else if (tenth_tick && !link_timeout_indication) begin
				if (tmo_cnt_reg + 8'h01 >= tmo_reg) begin
					link_timeout_indication <= 1'b1;
					stop_action_o           <= react;
				end
				tmo_cnt_reg <= tmo_cnt_reg + 8'h01;
			end
		end
	end

	// Error tolerance counter; a clean frame addressed to this station clears it.
	always @(posedge clk) begin
		if (!nrst) begin
			errcnt_reg                  <= 5'h00;
			link_error_limit_indication <= 1'b0;
		end else if (ce) begin
			if (good_fr) begin
				errcnt_reg                  <= 5'h00;
				link_error_limit_indication <= 1'b0;
			end else if (bad_fr) begin
				if (errcnt_reg != 5'h1F)
					errcnt_reg <= errcnt_reg + 5'h01;
				if (errcnt_reg + 5'h01 >= errlim_reg)
					link_error_limit_indication <= 1'b1;
			end
		end
	end

	// Turnaround: a reply request waits the programmed milliseconds after the frame end.
	always @(posedge clk) begin
		if (!nrst) begin
			turn_busy_reg <= 1'b0;
			turn_cnt_reg  <= 7'h00;
			reply_go_o    <= 1'b0;
			tx_o          <= 1'b1;
			tx_en_o       <= 1'b0;
		end else if (ce) begin
			reply_go_o <= 1'b0;
			if (for_me && reply_req_i && !turn_busy_reg) begin
				turn_busy_reg <= 1'b1;
				turn_cnt_reg  <= 7'h00;
			end else if (turn_busy_reg && ms_tick) begin
				if (turn_cnt_reg + 7'h01 >= turn_reg) begin
					turn_busy_reg <= 1'b0;
					reply_go_o    <= 1'b1;
					tx_en_o       <= 1'b1;
				end
				turn_cnt_reg <= turn_cnt_reg + 7'h01;
			end
			// The line idles high; driving stays off until a reply is allowed.
			if (frame_end_i)
				tx_en_o <= 1'b0;
			tx_o <= 1'b1;
		end
	end

	// Event vector for the sticky interrupt status.
	always @* begin
		ev_next = {`DSSCS_NEV{1'b0}};
		ev_next[`DSSCS_EV_TIMEOUT] = tenth_tick & ~link_timeout_indication & (tmo_reg != `DSSCS_TMO_RESET)
			& (tmo_cnt_reg + 8'h01 >= tmo_reg) & ~good_fr;
		ev_next[`DSSCS_EV_ERRLIM] = bad_fr & ~good_fr & (errcnt_reg + 5'h01 >= errlim_reg);
		ev_next[`DSSCS_EV_FRAME]  = good_fr;
		ev_next[`DSSCS_EV_ERROR]  = bad_fr;
	end

	// Read mux; unmapped addresses read zero but are still acknowledged.
	always @* begin
		case (wb_adr_i)
		`DSSCS_ADDR_CFG:      rd_next = cfg_reg;
		`DSSCS_ADDR_TMO:      rd_next = {24'h000000, tmo_reg};
		`DSSCS_ADDR_ERRLIM:   rd_next = {27'h0000000, errlim_reg};
		`DSSCS_ADDR_TURN:     rd_next = {25'h0000000, turn_reg};
		`DSSCS_ADDR_STATUS:   rd_next = {22'h000000, stop_action_o, turn_busy_reg, ascii, two_stop,
					seven, parity, link_error_limit_indication, link_timeout_indication};
		`DSSCS_ADDR_IRQ_STAT: rd_next = {28'h0000000, ist_reg};
		`DSSCS_ADDR_IRQ_EN:   rd_next = {28'h0000000, ien_reg};
		`DSSCS_ADDR_ERRCNT:   rd_next = {27'h0000000, errcnt_reg};
		default:              rd_next = 32'h00000000;
		endcase
	end

	// Wishbone slave: one-cycle acknowledge; out-of-range settings are clamped at write time.
	always @(posedge clk) begin
		if (!nrst) begin
			cfg_reg    <= `DSSCS_CFG_RESET;
			tmo_reg    <= `DSSCS_TMO_RESET;
			errlim_reg <= `DSSCS_ERRLIM_RESET;
			turn_reg   <= `DSSCS_TURN_RESET;
			ien_reg    <= {`DSSCS_NEV{1'b0}};
			ist_reg    <= {`DSSCS_NEV{1'b0}};
			wb_ack_o   <= 1'b0;
			wb_err_o   <= 1'b0;
			wb_dat_o   <= 32'h00000000;
			irq_o      <= 1'b0;
		end else if (ce) begin
			wb_ack_o <= wb_req;
			wb_err_o <= 1'b0;
			wb_dat_o <= wb_req ? rd_next : 32'h00000000;
			if (wr) begin
				case (wb_adr_i)
				`DSSCS_ADDR_CFG: begin
					cfg_reg <= wb_dat_i & 32'h00037FFF;
					if (wb_dat_i[5:0] < `DSSCS_STATION_MIN)
						cfg_reg[5:0] <= `DSSCS_STATION_MIN;
					else if (wb_dat_i[5:0] > `DSSCS_STATION_MAX)
						cfg_reg[5:0] <= `DSSCS_STATION_MAX;
					if (wb_dat_i[13:12] == 2'h3)
						cfg_reg[13:12] <= 2'h0;
				end
				`DSSCS_ADDR_TMO: tmo_reg <= wb_dat_i[7:0];
				`DSSCS_ADDR_ERRLIM:
					errlim_reg <= (wb_dat_i[4:0] < `DSSCS_ERRLIM_MIN) ? `DSSCS_ERRLIM_MIN :
						(wb_dat_i[4:0] > `DSSCS_ERRLIM_MAX) ? `DSSCS_ERRLIM_MAX : wb_dat_i[4:0];
				`DSSCS_ADDR_TURN:
					turn_reg <= (wb_dat_i[6:0] < `DSSCS_TURN_MIN) ? `DSSCS_TURN_MIN :
						(wb_dat_i[6:0] > `DSSCS_TURN_MAX) ? `DSSCS_TURN_MAX : wb_dat_i[6:0];
				`DSSCS_ADDR_IRQ_EN: ien_reg <= wb_dat_i[`DSSCS_NEV-1:0];
				default: ;
				endcase
			end
			// Set wins over clear so an event in the clearing cycle is kept.
			if (wr && wb_adr_i == `DSSCS_ADDR_IRQ_CLR)
				ist_reg <= (ist_reg & ~wb_dat_i[`DSSCS_NEV-1:0]) | ev_next;
			else
				ist_reg <= ist_reg | ev_next;
			irq_o <= |(ist_reg & ien_reg);
		end
	end
endmodule

// >>> verification/dsscs_asserts.sv
// Port checker of the serial slave supervisor.
`timescale 1ns/1ps
module dsscs_asserts (
	input logic        clk,
	input logic        nrst,
	input logic        ce,
	input logic [3:0]  wb_adr_i,
	input logic [31:0] wb_dat_i,
	input logic [3:0]  wb_sel_i,
	input logic        wb_we_i,
	input logic        wb_cyc_i,
	input logic        wb_stb_i,
	input logic [31:0] wb_dat_o,
	input logic        wb_ack_o,
	input logic        tx_o,
	input logic        tx_en_o,
	input logic        frame_end_i,
	input logic [7:0]  frame_addr_i,
	input logic        frame_bad_i,
	input logic        reply_req_i,
	input logic        reply_go_o,
	input logic        link_timeout_indication,
	input logic        link_error_limit_indication,
	input logic [1:0]  stop_action_o
);
	logic [31:0] cfg_q;
	logic [7:0]  tmo_q;
	logic [7:0]  st;
	logic        good;
	// Mirror of accepted writes; partial writes are ignored by the block, so they are here too.
	always_ff @(posedge clk) begin
		if (!nrst) begin
			cfg_q <= 32'h00000001;
			tmo_q <= 8'h00;
		end else if (wb_ack_o && wb_we_i && wb_sel_i == 4'hF) begin
			if (wb_adr_i == 4'h0) cfg_q <= wb_dat_i;
			if (wb_adr_i == 4'h1) tmo_q <= wb_dat_i[7:0];
		end
	end
	// Station number as the block clamps it.
	assign st = (cfg_q[5:0] == 6'h00) ? 8'h01 : (cfg_q[5:0] > 6'h20) ? 8'h20 : {2'h0, cfg_q[5:0]};
	assign good = frame_end_i && ce && !frame_bad_i && frame_addr_i == st;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && ce && !wb_ack_o |=> wb_ack_o) else $error("no ack");
	a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 4'h8 |-> wb_dat_o == 32'h00000000)
		else $error("unmapped data");
	a_tx_idle: assert property (!tx_en_o |-> tx_o) else $error("tx not idle");
	a_grant_enable: assert property (reply_go_o |=> tx_en_o) else $error("tx not enabled");
	a_turn_early: assert property (good && reply_req_i |=> !reply_go_o [*8]) else $error("early reply");
	a_good_clear: assert property (good |=> !link_timeout_indication && !link_error_limit_indication)
		else $error("not cleared");
	a_tmo_react: assert property (link_timeout_indication |-> stop_action_o == cfg_q[17:16])
		else $error("wrong reaction");
	a_tmo_off: assert property (tmo_q == 8'h00 |-> ##2 !link_timeout_indication) else $error("timeout on");
endmodule

// >>> verification/dsscs_master_model.sv
// Behavioural master that delivers frame events to the supervisor.
`timescale 1ns/1ps
module dsscs_master_model (
	input  logic       clk,
	input  logic       send,
	input  logic [7:0] addr,
	input  logic       bad,
	input  logic       req,
	output logic       frame_end_i = 1'b0,
	output logic [7:0] frame_addr_i = 8'h00,
	output logic       frame_bad_i = 1'b0,
	output logic       reply_req_i = 1'b0,
	output logic       rx_i = 1'b1
);
	// Outside a frame the qualifiers toggle, so a stale value can never look valid.
	always @(posedge clk) begin
		frame_end_i <= send;
		frame_addr_i <= send ? addr : ~frame_addr_i;
		frame_bad_i <= send ? bad : ~frame_bad_i;
		reply_req_i <= send ? req : ~reply_req_i;
		rx_i <= 1'b1;
	end
endmodule

// >>> verification/drive_serial_slave_comm_supervisor_tb.sv
// Self-checking bench of the serial slave supervisor.
`timescale 1ns/1ps
module drive_serial_slave_comm_supervisor_tb;
	localparam   TC = 10;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [3:0]  adr = 4'h0;
	logic [31:0] dat = 32'h00000000;
	logic        we = 1'b0;
	logic        cyc = 1'b0;
	logic        send = 1'b0;
	logic [7:0]  faddr = 8'h00;
	logic        fbad = 1'b0;
	logic        freq = 1'b0;
	logic [31:0] wb_dat_o, q, v, t, st, r;
	logic        wb_ack_o, tx_en_o, reply_go_o, tmo_ind, err_ind, irq_o, fe, fb, fr, rx;
	logic [7:0]  fa;
	logic [1:0]  stop_action_o;
	integer      seed = 82, error_cnt = 0, comparisons = 0, i, n;
	logic [3:0]  ca [6] = '{4'h0, 4'h0, 4'h2, 4'h2, 4'h3, 4'h3};
	logic [31:0] cv [6] = '{0, 40, 0, 25, 3, 70};
	logic [31:0] ce_ [6] = '{1, 32, 1, 20, 5, 65};
	// The clock enable stays high; freezing is not exercised.
	dsscs_top #(.TMO_TENTH_CYC(TC), .TURN_MS_CYC(5)) i_dut (.clk(clk), .nrst(nrst), .ce(1'b1), .wb_adr_i(adr),
		.wb_dat_i(dat), .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .wb_err_o(), .rx_i(rx), .tx_o(), .tx_en_o(tx_en_o), .frame_end_i(fe),
		.frame_addr_i(fa), .frame_bad_i(fb), .reply_req_i(fr), .reply_go_o(reply_go_o), .rx_bit_o(),
		.rx_strobe_o(), .link_timeout_indication(tmo_ind), .link_error_limit_indication(err_ind),
		.stop_action_o(stop_action_o), .irq_o(irq_o));
	dsscs_master_model i_mst (.clk(clk), .send(send), .addr(faddr), .bad(fbad), .req(freq), .frame_end_i(fe),
		.frame_addr_i(fa), .frame_bad_i(fb), .reply_req_i(fr), .rx_i(rx));
	initial forever #10 clk = ~clk;
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One classic cycle; the request is held until ack is sampled high.
	task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin @(posedge clk); n++; end while (wb_ack_o !== 1'b1 && n < 50);
		if (n >= 50) begin
			error_cnt++;
			stop_test;
		end
		q = wb_dat_o;
		cyc <= 1'b0;
		we <= 1'b0;
	endtask
	task rd(input logic [3:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h00000000);
		chk(q, e);
	endtask
	// Returns one cycle after the block has taken the frame.
	task frame(input logic [7:0] a, input logic b, input logic rq);
		@(posedge clk);
		send <= 1'b1;
		faddr <= a;
		fbad <= b;
		freq <= rq;
		@(posedge clk);
		send <= 1'b0;
		repeat (2) @(posedge clk);
	endtask
	task stop_test;
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		stop_test;
	end
	initial begin
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		rd(4'h0, 1);
		rd(4'h1, 0);
		rd(4'h9, 0);
		for (i = 0; i < 6; i++) begin
			wb(1'b1, ca[i], cv[i]);
			rd(ca[i], ce_[i]);
		end
		$display("reset and range test done");
		// Format set before any frame is sent, every rate code once.
		for (i = 0; i < 4; i++) begin
			st = $unsigned($random(seed)) % 32 + 1;
			t = $unsigned($random(seed)) % 3;
			r = $random(seed);
			v = {r[14], t[1:0], r[11], i[1:0], r[8], 2'h0, st[5:0]};
			wb(1'b1, 4'h0, v);
			rd(4'h0, v);
			rd(4'h4, {2'h3, 1'b0, v[8], v[11], v[14], v[13:12], 2'h0});
		end
		$display("format test done");
		wb(1'b1, 4'h2, 3);
		frame(st, 1'b1, 1'b0);
		frame(8'hFF, 1'b1, 1'b0);
		chk(err_ind, 0);
		frame(st, 1'b1, 1'b0);
		chk(err_ind, 1);
		frame(8'hFF, 1'b0, 1'b0);
		rd(4'h8, 3);
		frame(st, 1'b0, 1'b0);
		chk(err_ind, 0);
		rd(4'h8, 0);
		$display("error tolerance test done");
		wb(1'b1, 4'h1, 2);
		wb(1'b1, 4'h7, 1);
		for (i = 0; i < 4; i++) begin
			wb(1'b1, 4'h0, st | (i << 16));
			frame(st, 1'b0, 1'b0);
			repeat (TC) @(posedge clk);
			chk(tmo_ind, 0);
			repeat (2 * TC) @(posedge clk);
			chk(tmo_ind, 1);
			chk(stop_action_o, i);
			chk(irq_o, 1);
			frame(st, 1'b0, 1'b0);
			wb(1'b1, 4'h6, 32'h0000000F);
			repeat (2) @(posedge clk);
			chk(irq_o, 0);
		end
		wb(1'b1, 4'h7, 0);
		repeat (3 * TC) @(posedge clk);
		chk(irq_o, 0);
		wb(1'b1, 4'h1, 0);
		repeat (300) @(posedge clk);
		chk(tmo_ind, 0);
		$display("timeout test done");
		for (i = 0; i < 2; i++) begin
			t = i ? $unsigned($random(seed)) % 61 + 5 : 5;
			wb(1'b1, 4'h3, t);
			frame(st, 1'b0, 1'b1);
			n = 0;
			while (reply_go_o !== 1'b1 && n < 400) begin @(posedge clk); n++; end
			chk(n >= t * 5 - 2 && n <= t * 5 + 3, 1);
			@(posedge clk);
			chk(tx_en_o, 1);
		end
		$display("turnaround test done");
		stop_test;
	end
endmodule
bind dsscs_top dsscs_asserts i_chk (.*);
